// file: bench/ocl_analog_model.sv
// behavioural model of the trip comparator and soft-start ramp
`timescale 1ns/100ps
module ocl_analog_model #(
  parameter int         RAMP_CYC = 6,
  parameter logic [7:0] LOAD_CUR = 8'h5a
) (
  input  wire logic       sys_clk_i,
  input  wire logic       pwm_enable_i,
  input  wire logic       trip_cmd_i,
  output logic            limit_trip_o,
  output logic            vout_low_o,
  output logic            ramp_done_o,
  output logic [7:0]      load_current_o
);
  int run_cnt = 0;
  always_ff @(posedge sys_clk_i) begin
    run_cnt <= pwm_enable_i ? run_cnt + 1 : 0;
  end
  // output only rises while the phases switch
  assign vout_low_o     = (run_cnt < 3);
  assign ramp_done_o    = (run_cnt >= RAMP_CYC);
  assign limit_trip_o   = trip_cmd_i;
  assign load_current_o = LOAD_CUR;
endmodule

// file: bench/ocl_latchoff_ctrl_bench.sv
// self-checking bench for the overcurrent latchoff control
`timescale 1ns/100ps
`include "ocl_consts.svh"
module ocl_latchoff_ctrl_bench;
  import ocl_pkg::*;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] wd;
    logic [7:0] rexp;
    logic [7:0] lexp;
  } ocl_row_t;
  localparam ocl_row_t ROWS [6] = '{'{8'he2, 8'h05, 8'h05, 8'h15},
    '{8'he2, 8'hff, 8'h1f, 8'h2f}, '{8'hd4, 8'hff, 8'h07, 8'h2f},
    '{8'h55, 8'haa, 8'h00, 8'h2f}, '{8'he2, 8'h00, 8'h00, 8'h10},
    '{8'hd4, 8'h00, 8'h00, 8'h10}};
  logic clk = 0, rst_n = 0, en = 0, uvlo = 0, trip_cmd = 0;
  logic trip, vlow, rdone, wr_s = 0, rd_s = 0, rvalid, pwm, clamp;
  logic fault, timing, early_lo = 0, saw_clamp = 0, bad_pwm = 0;
  logic [7:0] cur, code = 0, wdata = 0, rdata;
  logic [4:0] trim;
  logic [5:0] lim;
  logic [6:0] ll;
  ocl_state_t st;
  int bad_count = 0, comparisons = 0, cyc = 0;
  ocl_latchoff_ctrl #(.STEP_CYC(4)) uut (.sys_clk_i(clk), .rst_n_i(rst_n),
    .enable_i(en), .uvlo_ok_i(uvlo), .limit_trip_i(trip),
    .vout_low_i(vlow), .ramp_done_i(rdone), .load_current_i(cur),
    .cmd_code_i(code), .cmd_wr_i(wr_s), .cmd_wdata_i(wdata),
    .cmd_rd_i(rd_s), .cmd_rdata_o(rdata), .cmd_rvalid_o(rvalid),
    .trim_o(trim), .limit_scale_o(lim), .load_line_scale_o(ll),
    .pwm_enable_o(pwm), .secondary_clamp_o(clamp),
    .latched_fault_o(fault), .latchoff_timing_o(timing), .state_o(st));
  ocl_analog_model partner (.sys_clk_i(clk), .pwm_enable_i(pwm),
    .trip_cmd_i(trip_cmd), .limit_trip_o(trip), .vout_low_o(vlow),
    .ramp_done_o(rdone), .load_current_o(cur));
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (timing && st != S_RUN) early_lo <= 1'b1;
    if (timing && !pwm) bad_pwm <= 1'b1;
    if (clamp) saw_clamp <= 1'b1;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk);
    code <= c;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    @(posedge clk);
    code <= c;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(8'(rvalid), 8'h01);
    d = rdata;
  endtask
  task automatic wait_st(input ocl_state_t s, output int n);
    n = 0;
    while (st !== s && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(st), 8'(s));
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    int n;
    logic [7:0] d;
    repeat (3) @(posedge clk);
    #1;
    chk(8'(trim), 8'h10);
    chk(8'(lim), 8'h20);
    chk(8'(ll), 8'h40);
    chk(8'(st), 8'(S_IDLE));
    chk({6'h00, fault, pwm}, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    rd(`OCL_CMD_TRIM, d);
    chk(d, 8'h10);
    rd(`OCL_CMD_DELAY, d);
    chk(d, 8'h03);
    $display("reset test done");
    foreach (ROWS[i]) begin
      wr(ROWS[i].code, ROWS[i].wd);
      rd(ROWS[i].code, d);
      chk(d, ROWS[i].rexp);
      chk(8'(lim), ROWS[i].lexp);
    end
    wr(`OCL_CMD_LL_CAL, 8'h00);
    wr(`OCL_CMD_LL_SET, 8'h00);
    chk(8'(ll), 8'h20);
    wr(`OCL_CMD_LL_SET, 8'h1f);
    chk(8'(ll), 8'h3f);
    rd(`OCL_CMD_CURRENT, d);
    chk(d, 8'h5a);
    $display("register table done");
    @(posedge clk);
    trip_cmd <= 1'b1;
    en <= 1'b1;
    uvlo <= 1'b1;
    wait_st(S_RUN, n);
    chk(8'(early_lo), 8'h00);
    chk(8'(saw_clamp), 8'h01);
    wait_st(S_LATCH, n);
    chk(8'(n), 8'h10);
    chk({6'h00, fault, pwm}, 8'h02);
    chk(8'(bad_pwm), 8'h00);
    @(posedge clk);
    trip_cmd <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk(8'(fault), 8'h01);
    @(posedge clk);
    en <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk({fault, 4'h0, st}, 8'(S_IDLE));
    @(posedge clk);
    en <= 1'b1;
    $display("latchoff test done");
    wait_st(S_RUN, n);
    @(posedge clk);
    trip_cmd <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk({6'h00, timing, pwm}, 8'h03);
    @(posedge clk);
    trip_cmd <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    chk({fault, 4'h0, st}, 8'(S_RUN));
    // code 1 doubles the base period, so the latchoff takes 32 cycles
    wr(`OCL_CMD_DELAY, 8'h01);
    @(posedge clk);
    trip_cmd <= 1'b1;
    wait_st(S_LATCH, n);
    chk(8'(n), 8'h22);
    @(posedge clk);
    uvlo <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk({fault, 4'h0, st}, 8'(S_IDLE));
    $display("recovery test done");
    wr(`OCL_CMD_TRIM, 8'h05);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(8'(trim), 8'h10);
    chk(8'(lim), 8'h20);
    rd(`OCL_CMD_DELAY, d);
    chk(d, 8'h03);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule

// file: include/ocl_consts.svh
// constants for the overcurrent latchoff control block
`ifndef OCL_CONSTS_SVH
`define OCL_CONSTS_SVH
`define OCL_CMD_DELAY    8'hD4
`define OCL_CMD_LL_CAL   8'hDE
`define OCL_CMD_LL_SET   8'hDF
`define OCL_CMD_TRIM     8'hE2
`define OCL_CMD_CURRENT  8'h8C
`define OCL_TRIM_RST     5'h10
`define OCL_LL_RST       8'h10
`define OCL_DELAY_RST    3'h3
`define OCL_TRIM_OFFSET  6'h10
`define OCL_LL_OFFSET    7'h20
`define OCL_LATCH_SHIFT  2
`define OCL_CLK_NS       25
`define OCL_STEP_NS      500000
`define OCL_STEP_CYC     ((`OCL_STEP_NS + `OCL_CLK_NS - 1) / `OCL_CLK_NS)
`endif

// file: include/ocl_pkg.sv
// types for the overcurrent latchoff control block
package ocl_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_TD1, S_RAMP1, S_TD3, S_RAMP2, S_TD5, S_RUN, S_LATCH
  } ocl_state_t;

  typedef struct packed {
    ocl_state_t  st;
    logic [19:0] dly_cnt;
    logic [19:0] lo_cnt;
    logic [4:0]  trim;
    logic [7:0]  ll_cal;
    logic [7:0]  ll_set;
    logic [2:0]  dly_code;
    logic        en_s1;
    logic        en_s2;
    logic        uv_s1;
    logic        uv_s2;
    logic        trip_s1;
    logic        trip_s2;
    logic        low_s1;
    logic        low_s2;
    logic        ramp_s1;
    logic        ramp_s2;
    logic [7:0]  cur_s1;
    logic [7:0]  cur_s2;
    logic        fault;
    logic        pwm_en;
    logic        clamp;
    logic        lo_run;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [5:0]  lim_scale;
    logic [6:0]  ll_scale;
  } ocl_regs_t;
endpackage

// file: src/ocl_latchoff_ctrl.sv
// overcurrent trim, startup delays and latchoff control
`timescale 1ns/100ps
`include "ocl_consts.svh"

module ocl_latchoff_ctrl #(
  parameter int STEP_CYC = `OCL_STEP_CYC
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             enable_i,
  input  wire logic             uvlo_ok_i,
  input  wire logic             limit_trip_i,
  input  wire logic             vout_low_i,
  input  wire logic             ramp_done_i,
  input  wire logic [7:0]       load_current_i,
  input  wire logic [7:0]       cmd_code_i,
  input  wire logic             cmd_wr_i,
  input  wire logic [7:0]       cmd_wdata_i,
  input  wire logic             cmd_rd_i,
  output logic [7:0]            cmd_rdata_o,
  output logic                  cmd_rvalid_o,
  output logic [4:0]            trim_o,
  output logic [5:0]            limit_scale_o,
  output logic [6:0]            load_line_scale_o,
  output logic                  pwm_enable_o,
  output logic                  secondary_clamp_o,
  output logic                  latched_fault_o,
  output logic                  latchoff_timing_o,
  output ocl_pkg::ocl_state_t   state_o
);
  import ocl_pkg::*;

  ocl_regs_t   q_reg;
  ocl_regs_t   q_next;
  logic [19:0] period;
  logic [19:0] lo_period;

  function automatic logic hit(input logic [7:0] code,
                               input logic [7:0] cmd);
    hit = (code == cmd);
  endfunction

  function automatic logic is_startup(input ocl_state_t s);
    is_startup = (s != S_IDLE) && (s != S_RUN) && (s != S_LATCH);
  endfunction

  // base period is one half-millisecond step per code plus one
  assign period    = 20'(({17'h0_0000, q_reg.dly_code} + 20'h0_0001)
                     * 20'(STEP_CYC));
  assign lo_period = period << `OCL_LATCH_SHIFT;

  always_comb begin
    q_next = q_reg;
    q_next.en_s1   = enable_i;
    q_next.en_s2   = q_reg.en_s1;
    q_next.uv_s1   = uvlo_ok_i;
    q_next.uv_s2   = q_reg.uv_s1;
    q_next.trip_s1 = limit_trip_i;
    q_next.trip_s2 = q_reg.trip_s1;
    q_next.low_s1  = vout_low_i;
    q_next.low_s2  = q_reg.low_s1;
    q_next.ramp_s1 = ramp_done_i;
    q_next.ramp_s2 = q_reg.ramp_s1;
    q_next.cur_s1  = load_current_i;
    q_next.cur_s2  = q_reg.cur_s1;

    if (cmd_wr_i) begin
      if (hit(cmd_code_i, `OCL_CMD_TRIM)) begin
        q_next.trim = cmd_wdata_i[4:0];
      end
      if (hit(cmd_code_i, `OCL_CMD_DELAY)) begin
        q_next.dly_code = cmd_wdata_i[2:0];
      end
      if (hit(cmd_code_i, `OCL_CMD_LL_CAL)) begin
        q_next.ll_cal = cmd_wdata_i;
      end
      if (hit(cmd_code_i, `OCL_CMD_LL_SET)) begin
        q_next.ll_set = cmd_wdata_i;
      end
    end

    q_next.rvalid = cmd_rd_i;
    q_next.rdata  = 8'h00;
    if (cmd_rd_i) begin
      if (hit(cmd_code_i, `OCL_CMD_TRIM)) begin
        q_next.rdata = {3'h0, q_reg.trim};
      end else if (hit(cmd_code_i, `OCL_CMD_DELAY)) begin
        q_next.rdata = {5'h00, q_reg.dly_code};
      end else if (hit(cmd_code_i, `OCL_CMD_LL_CAL)) begin
        q_next.rdata = q_reg.ll_cal;
      end else if (hit(cmd_code_i, `OCL_CMD_LL_SET)) begin
        q_next.rdata = q_reg.ll_set;
      end else if (hit(cmd_code_i, `OCL_CMD_CURRENT)) begin
        q_next.rdata = q_reg.cur_s2;
      end
    end

    q_next.lim_scale = `OCL_TRIM_OFFSET + {1'b0, q_next.trim};
    q_next.ll_scale  = `OCL_LL_OFFSET + {2'h0, q_next.ll_cal[4:0]}
                       + {2'h0, q_next.ll_set[4:0]};

    case (q_reg.st)
      S_IDLE: begin
        q_next.dly_cnt = 20'h0_0000;
        if (q_reg.en_s2 && q_reg.uv_s2) begin
          q_next.st = S_TD1;
        end
      end
      S_TD1, S_TD3, S_TD5: begin
        if (q_reg.dly_cnt >= period - 20'h0_0001) begin
          q_next.dly_cnt = 20'h0_0000;
          q_next.st = (q_reg.st == S_TD1) ? S_RAMP1 :
                      (q_reg.st == S_TD3) ? S_RAMP2 : S_RUN;
        end else begin
          q_next.dly_cnt = q_reg.dly_cnt + 20'h0_0001;
        end
      end
      S_RAMP1: begin
        if (q_reg.ramp_s2) begin
          q_next.st = S_TD3;
        end
      end
      S_RAMP2: begin
        if (q_reg.ramp_s2) begin
          q_next.st = S_TD5;
        end
      end
      S_RUN: begin
        if (q_reg.trip_s2) begin
          if (q_reg.lo_cnt >= lo_period - 20'h0_0001) begin
            q_next.st     = S_LATCH;
            q_next.fault  = 1'b1;
            q_next.lo_cnt = 20'h0_0000;
          end else begin
            q_next.lo_cnt = q_reg.lo_cnt + 20'h0_0001;
          end
        end else begin
          q_next.lo_cnt = 20'h0_0000;
        end
      end
      S_LATCH: begin
        q_next.fault = 1'b1;
      end
      default: begin
        q_next.st = S_IDLE;
      end
    endcase

    // enable low or supply loss aborts everything and clears the latch
    if (!q_reg.en_s2 || !q_reg.uv_s2) begin
      q_next.st      = S_IDLE;
      q_next.fault   = 1'b0;
      q_next.lo_cnt  = 20'h0_0000;
      q_next.dly_cnt = 20'h0_0000;
    end

    q_next.lo_run = (q_next.st == S_RUN) && (q_next.lo_cnt != 20'h0_0000);
    q_next.pwm_en = (q_next.st == S_RAMP1) || (q_next.st == S_TD3) ||
                    (q_next.st == S_RAMP2) || (q_next.st == S_TD5) ||
                    (q_next.st == S_RUN);
    q_next.clamp  = is_startup(q_next.st) && q_reg.low_s2;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      q_reg           <= '0;
      q_reg.st        <= S_IDLE;
      q_reg.trim      <= `OCL_TRIM_RST;
      q_reg.dly_code  <= `OCL_DELAY_RST;
      q_reg.ll_cal    <= `OCL_LL_RST;
      q_reg.ll_set    <= `OCL_LL_RST;
      q_reg.lim_scale <= `OCL_TRIM_OFFSET + {1'b0, `OCL_TRIM_RST};
      q_reg.ll_scale  <= `OCL_LL_OFFSET + 7'(`OCL_LL_RST)
                         + 7'(`OCL_LL_RST);
    end else begin
      q_reg <= q_next;
    end
  end

  assign cmd_rdata_o       = q_reg.rdata;
  assign cmd_rvalid_o      = q_reg.rvalid;
  assign trim_o            = q_reg.trim;
  assign limit_scale_o     = q_reg.lim_scale;
  assign load_line_scale_o = q_reg.ll_scale;
  assign pwm_enable_o      = q_reg.pwm_en;
  assign secondary_clamp_o = q_reg.clamp;
  assign latched_fault_o   = q_reg.fault;
  assign latchoff_timing_o = q_reg.lo_run;
  assign state_o           = q_reg.st;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  trim_reset_a: assert property (
    $past(!rst_n_i) |-> trim_o == `OCL_TRIM_RST)
    else $error("trim not at default after reset");
  trim_write_a: assert property (
    (cmd_wr_i && cmd_code_i == `OCL_CMD_TRIM)
    |=> trim_o == $past(cmd_wdata_i[4:0]))
    else $error("trim write not taken");
  limit_scale_a: assert property (
    $past(rst_n_i) |-> limit_scale_o == `OCL_TRIM_OFFSET + 6'(trim_o))
    else $error("limit scale does not follow trim");
  ll_scale_a: assert property (
    $past(rst_n_i) |-> load_line_scale_o == `OCL_LL_OFFSET
      + 7'(q_reg.ll_cal[4:0]) + 7'(q_reg.ll_set[4:0]))
    else $error("load-line scale wrong");
  latch_cause_a: assert property (
    $rose(latched_fault_o)
    |-> $past(state_o) == S_RUN && $past(q_reg.trip_s2))
    else $error("latch without running trip");
  latch_length_a: assert property (
    $rose(latched_fault_o)
    |-> $past(q_reg.lo_cnt) == (period << `OCL_LATCH_SHIFT) - 20'h0_0001)
    else $error("latchoff length not four periods");
  startup_first_a: assert property (
    is_startup(state_o) |-> q_reg.lo_cnt == 20'h0_0000)
    else $error("latchoff timing during startup");
  cancel_timer_a: assert property (
    (state_o == S_RUN && !q_reg.trip_s2 && q_reg.en_s2 && q_reg.uv_s2)
    |=> q_reg.lo_cnt == 20'h0_0000 && pwm_enable_o)
    else $error("timer not cancelled");
  // a one-cycle enable dip may restart at once, so only the next cycle
  clear_latch_a: assert property (
    (latched_fault_o && !q_reg.en_s2)
    |=> !latched_fault_o && state_o == S_IDLE)
    else $error("enable low did not clear latch");
  hold_latch_a: assert property (
    (latched_fault_o && q_reg.en_s2 && q_reg.uv_s2)
    |=> latched_fault_o && !pwm_enable_o)
    else $error("latch released without enable toggle");
  clamp_scope_a: assert property (
    secondary_clamp_o |-> is_startup(state_o))
    else $error("clamp outside startup");
  read_current_a: assert property (
    (cmd_rd_i && cmd_code_i == `OCL_CMD_CURRENT)
    |=> cmd_rvalid_o && cmd_rdata_o == $past(q_reg.cur_s2))
    else $error("current readback wrong");
  delay_write_a: assert property (
    (cmd_wr_i && cmd_code_i == `OCL_CMD_DELAY)
    |=> q_reg.dly_code == $past(cmd_wdata_i[2:0]))
    else $error("delay code write not taken");

  reach_run_c: cover property (state_o == S_RUN);
  latch_c:     cover property ($rose(latched_fault_o));
  cancel_c:    cover property (latchoff_timing_o ##1 !latchoff_timing_o
                               && state_o == S_RUN);
  clamp_c:     cover property (secondary_clamp_o);
endmodule
